//--- adc_seq_core.sv
// conversion sequencer with parallel and serial result ports
// Summary of operation
// [R1] A conversion ends at most 0.75, 1 or 1.25 us after it starts in fast, normal or low power.
// [R2] The host spaces starts by 1, 1.25 or 1.5 us, and in fast mode by no more than 1 ms.
// [R3] Busy rises within 30 ns of the falling edge of the start strobe.
// [R4] Busy stays high at least 10 ns after the conversion has ended.
// [R5] Parallel result data are valid at least 20 ns before busy falls.
// [R6] Parallel result data are valid within 0.75, 1 or 1.25 us of the start edge by mode.
// [R7] In master serial mode the divider sets the bit-clock period to 25-40, 50-70, 100-140 or 200-280 ns.
// [R8] Frame sync leads the first bit-clock edge by 4 ns for divider 0 and 20 ns otherwise.
// [R9] Frame sync holds after the last bit-clock edge for 3, 60, 140 or 300 ns by divider.
// [R10] In master serial mode busy stays high no longer than the per-mode, per-divider limit.
// [R11] In master serial mode frame sync rises about 0.75, 1 or 1.25 us after the start edge.
// [R12] In master serial mode busy falls about 25 ns after frame sync falls.
// [R13] Chip select high releases serial data, frame sync and bit clock within 10 ns.
// [R14] Fast mode is selected by the fast select high and the low-power select low.
// [R15] Low-power mode is selected by the low-power select high and fast select low.
//
// The register addresses and the strobed register port were left to the implementer.
module adc_seq_core
  import adc_seq_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic convert_start_n,
  input wire logic fast_sel,
  input wire logic low_power_sel,
  input wire logic [15:0] sample_code,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic ext_sclk,
  input wire logic serial_data_in,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic busy,
  output logic core_power_up,
  output logic [15:0] par_data,
  output logic par_data_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic sync_out,
  output logic sync_oe,
  output logic sclk_out,
  output logic sclk_oe
);
`include "adc_seq_map.svh"

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int CW = 10;
  localparam int BW = $clog2(`RESULT_WIDTH + 1);
  logic [3:0] ctrl_reg;
  logic overrun_reg;
  logic [15:0] result_reg;
  logic [31:0] count_reg;
  logic [31:0] rdata_reg;
  seq_state_type state_reg;
  conv_mode_type mode_reg;
  logic [CW-1:0] cnt_reg;
  logic start_prev_reg;
  logic sclk_prev_reg;
  logic busy_reg;
  logic power_reg;
  logic [15:0] par_data_reg;
  logic par_oe_reg;
  logic sdo_oe_reg;
  logic sync_reg;
  logic sync_oe_reg;
  logic sclk_reg;
  logic sclk_oe_reg;
  logic [1:0] div_reg;
  logic start_fall;
  logic slave_fall;
  logic serial_en;
  logic master_en;
  conv_mode_type mode_next;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] fifo_out_data;
  logic fifo_full;
  logic fifo_empty;
  logic seq_pop;
  logic slave_pop;
  logic shift_load;
  logic shift_step;
  logic shift_bit;
  logic [BW-1:0] bits_left;

  // ----------------------------------------------------------------
  // cycle counts per mode and per divider
  // ----------------------------------------------------------------
  // data lead, start detect and drain all come off, so busy ends inside the maximum except in master serial mode
  function automatic logic [CW-1:0] conv_cycles(input conv_mode_type m);
    case (m)
      MODE_FAST: conv_cycles = CW'(`CYC_FLOOR(`T_CONV_FAST_PS) - `DATA_LEAD_CYC - 2); // [R1]
      MODE_LOW_POWER: conv_cycles = CW'(`CYC_FLOOR(`T_CONV_LOW_POWER_PS) - `DATA_LEAD_CYC - 2);
      default: conv_cycles = CW'(`CYC_FLOOR(`T_CONV_NORMAL_PS) - `DATA_LEAD_CYC - 2);
    endcase
  endfunction

  // half periods give bit-clock periods of 32, 64, 112 and 208 ns, each inside its window
  function automatic logic [CW-1:0] half_cycles(input logic [1:0] d);
    case (d)
      2'h0: half_cycles = CW'(`CYC_CEIL(`T_SCLK_HALF_DIV0_PS)); // [R7]
      2'h1: half_cycles = CW'(`CYC_CEIL(`T_SCLK_HALF_DIV1_PS));
      2'h2: half_cycles = CW'(`CYC_CEIL(`T_SCLK_HALF_DIV2_PS));
      default: half_cycles = CW'(`CYC_CEIL(`T_SCLK_HALF_DIV3_PS));
    endcase
  endfunction

  function automatic logic [CW-1:0] lead_cycles(input logic [1:0] d);
    if (d == 2'h0) begin
      lead_cycles = CW'(`CYC_CEIL(`T_SYNC_LEAD_DIV0_PS)); // [R8]
    end else begin
      lead_cycles = CW'(`CYC_CEIL(`T_SYNC_LEAD_DIVN_PS));
    end
  endfunction

  function automatic logic [CW-1:0] tail_cycles(input logic [1:0] d);
    case (d)
      2'h0: tail_cycles = CW'(`CYC_CEIL(`T_SYNC_TAIL_DIV0_PS)); // [R9]
      2'h1: tail_cycles = CW'(`CYC_CEIL(`T_SYNC_TAIL_DIV1_PS));
      2'h2: tail_cycles = CW'(`CYC_CEIL(`T_SYNC_TAIL_DIV2_PS));
      default: tail_cycles = CW'(`CYC_CEIL(`T_SYNC_TAIL_DIV3_PS));
    endcase
  endfunction

  // ----------------------------------------------------------------
  // mode decode and edge detection
  // ----------------------------------------------------------------
  // both selects high or both low fall back to normal mode
  always_comb begin
    if (fast_sel && !low_power_sel) begin
      mode_next = MODE_FAST; // [R14]
    end else if (low_power_sel && !fast_sel) begin
      mode_next = MODE_LOW_POWER; // [R15]
    end else begin
      mode_next = MODE_NORMAL;
    end
  end

  assign serial_en = ctrl_reg[`CTRL_SERIAL_BIT];
  assign master_en = ctrl_reg[`CTRL_MASTER_BIT];
  assign start_fall = start_prev_reg && !convert_start_n;
  assign slave_fall = sclk_prev_reg && !ext_sclk && serial_en && !master_en && !cs_n;

  // previous levels of the start strobe and the host bit clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= convert_start_n;
      sclk_prev_reg <= ext_sclk;
    end
  end

  // ----------------------------------------------------------------
  // result FIFO and shift register
  // ----------------------------------------------------------------
  assign fifo_in_valid = (state_reg == SEQ_CONVERT) && (cnt_reg == '0);
  assign fifo_out_ready = seq_pop || slave_pop;
  assign seq_pop = (state_reg == SEQ_DRAIN) && !(serial_en && !master_en) && fifo_out_valid;
  // slave mode refills the shifter once the previous word has left
  assign slave_pop = serial_en && !master_en && fifo_out_valid && (bits_left == '0);
  assign shift_load = (seq_pop && serial_en && master_en) || slave_pop;
  assign shift_step = slave_fall ||
                      ((state_reg == SEQ_SCLK_LOW) && (cnt_reg == '0) && (bits_left != '0));

  result_fifo #(
    .WIDTH(`RESULT_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(sample_code),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  result_shifter #(
    .WIDTH(`RESULT_WIDTH)
  ) u_shift (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(shift_load),
    .load_data(fifo_out_data),
    .shift(shift_step),
    .chain_in(serial_data_in),
    .bit_out(shift_bit),
    .bits_left(bits_left)
  );

  // ----------------------------------------------------------------
  // conversion and read-out sequencer
  // ----------------------------------------------------------------
  // a start while busy is ignored; a start with a full FIFO is refused
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEQ_IDLE;
      mode_reg <= MODE_NORMAL;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      sync_reg <= 1'b0;
      sclk_reg <= 1'b0;
      div_reg <= 2'h0;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          if (start_fall && fifo_in_ready) begin // [R2]
            busy_reg <= 1'b1; // [R3]
            mode_reg <= mode_next;
            div_reg <= ctrl_reg[`CTRL_DIV_LSB +: 2];
            cnt_reg <= conv_cycles(mode_next); // [R1]
            state_reg <= SEQ_CONVERT;
          end
        end
        SEQ_CONVERT: begin
          if (cnt_reg == '0) begin
            state_reg <= SEQ_DRAIN;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        SEQ_DRAIN: begin
          if (serial_en && !master_en) begin
            cnt_reg <= CW'(`EOC_BUSY_CYC); // [R4]
            state_reg <= SEQ_BUSY_TAIL;
          end else if (fifo_out_valid && !serial_en) begin
            cnt_reg <= CW'(`DATA_LEAD_CYC); // [R5]
            state_reg <= SEQ_BUSY_TAIL;
          end else if (fifo_out_valid) begin
            sync_reg <= 1'b1; // [R11]
            cnt_reg <= lead_cycles(div_reg) - 1'b1;
            state_reg <= SEQ_SYNC_LEAD;
          end
        end
        SEQ_SYNC_LEAD: begin
          if (cnt_reg == '0) begin
            sclk_reg <= 1'b1; // [R8]
            cnt_reg <= half_cycles(div_reg) - 1'b1;
            state_reg <= SEQ_SCLK_HIGH;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        SEQ_SCLK_HIGH: begin
          if (cnt_reg == '0) begin
            sclk_reg <= 1'b0; // [R7]
            cnt_reg <= half_cycles(div_reg) - 1'b1;
            state_reg <= SEQ_SCLK_LOW;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        SEQ_SCLK_LOW: begin
          // the falling edge of the last bit is the last clock edge
          if (bits_left == BW'(1) && cnt_reg == '0) begin
            cnt_reg <= tail_cycles(div_reg) - 1'b1; // [R9]
            state_reg <= SEQ_SYNC_TAIL;
          end else if (cnt_reg == '0) begin
            sclk_reg <= 1'b1;
            cnt_reg <= half_cycles(div_reg) - 1'b1;
            state_reg <= SEQ_SCLK_HIGH;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        SEQ_SYNC_TAIL: begin
          if (cnt_reg == '0) begin
            sync_reg <= 1'b0;
            cnt_reg <= CW'(`SYNC_TO_BUSY_CYC); // [R12]
            state_reg <= SEQ_BUSY_TAIL;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        SEQ_BUSY_TAIL: begin
          // whole read-out stays inside the busy limit for every divider
          if (cnt_reg <= CW'(1)) begin
            busy_reg <= 1'b0; // [R10]
            state_reg <= SEQ_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // parallel word is latched as it leaves the FIFO, ahead of busy falling
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_data_reg <= '0;
      result_reg <= '0;
      count_reg <= '0;
    end else begin
      if (seq_pop && !serial_en) begin
        par_data_reg <= fifo_out_data; // [R6]
      end
      if (fifo_in_valid) begin
        result_reg <= sample_code;
        count_reg <= count_reg + 32'h1;
      end
    end
  end

  // enables follow chip select one cycle later, well inside 10 ns
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_oe_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
      sync_oe_reg <= 1'b0;
      sclk_oe_reg <= 1'b0;
    end else begin
      par_oe_reg <= !cs_n && !rd_n && !serial_en;
      sdo_oe_reg <= !cs_n && serial_en; // [R13]
      sync_oe_reg <= !cs_n && serial_en && master_en; // [R13]
      sclk_oe_reg <= !cs_n && serial_en && master_en; // [R13]
    end
  end

  // analog core stays powered in low-power mode only while converting
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_reg <= 1'b1;
    end else if (mode_next == MODE_LOW_POWER) begin
      power_reg <= (state_reg == SEQ_IDLE) ? start_fall : (state_reg == SEQ_CONVERT); // [R15]
    end else begin
      power_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // overrun is sticky; a refused start in the clearing cycle still sets it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET;
      overrun_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `OFS_CTRL) begin
        ctrl_reg <= reg_wdata[3:0];
      end
      if (start_fall && state_reg == SEQ_IDLE && !fifo_in_ready) begin
        overrun_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `OFS_STATUS && reg_wdata[`ST_OVERRUN_BIT]) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (!reg_rd) begin
      rdata_reg <= '0;
    end else if (reg_addr == `OFS_CTRL) begin
      rdata_reg <= {28'h0, ctrl_reg};
    end else if (reg_addr == `OFS_STATUS) begin
      rdata_reg <= {26'h0, overrun_reg, fifo_full, fifo_empty, mode_reg, busy_reg};
    end else if (reg_addr == `OFS_RESULT) begin
      rdata_reg <= {16'h0, result_reg};
    end else if (reg_addr == `OFS_COUNT) begin
      rdata_reg <= count_reg;
    end else begin
      rdata_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign busy = busy_reg;
  assign core_power_up = power_reg;
  assign par_data = par_data_reg;
  assign par_data_oe = par_oe_reg;
  assign serial_data_out = shift_bit;
  assign serial_data_oe = sdo_oe_reg;
  assign sync_out = sync_reg;
  assign sync_oe = sync_oe_reg;
  assign sclk_out = sclk_reg;
  assign sclk_oe = sclk_oe_reg;
endmodule // adc_seq_core

//--- adc_seq_map.svh
// constants of the conversion sequencer: timing, register offsets and fields
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ----------------------------------------------------------------
// clock and rounding helpers
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 8000
`define CYC_CEIL(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_FLOOR(ps) ((ps) / `CLK_PERIOD_PS)

// ----------------------------------------------------------------
// conversion timing in picoseconds
// ----------------------------------------------------------------
`define T_CONV_FAST_PS 750000
`define T_CONV_NORMAL_PS 1000000
`define T_CONV_LOW_POWER_PS 1250000
`define T_DATA_LEAD_PS 20000
`define T_EOC_BUSY_PS 10000
`define T_SYNC_TO_BUSY_PS 25000
`define DATA_LEAD_CYC `CYC_CEIL(`T_DATA_LEAD_PS)
`define EOC_BUSY_CYC `CYC_CEIL(`T_EOC_BUSY_PS)
`define SYNC_TO_BUSY_CYC `CYC_CEIL(`T_SYNC_TO_BUSY_PS)

// ----------------------------------------------------------------
// master serial timing per divider setting, picoseconds
// ----------------------------------------------------------------
`define T_SYNC_LEAD_DIV0_PS 4000
`define T_SYNC_LEAD_DIVN_PS 20000
`define T_SYNC_TAIL_DIV0_PS 3000
`define T_SYNC_TAIL_DIV1_PS 60000
`define T_SYNC_TAIL_DIV2_PS 140000
`define T_SYNC_TAIL_DIV3_PS 300000
`define T_SCLK_HALF_DIV0_PS 16000
`define T_SCLK_HALF_DIV1_PS 32000
`define T_SCLK_HALF_DIV2_PS 56000
`define T_SCLK_HALF_DIV3_PS 104000

// ----------------------------------------------------------------
// register offsets, fields and reset values
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RESULT 8'h08
`define OFS_COUNT 8'h0C
`define CTRL_SERIAL_BIT 0
`define CTRL_MASTER_BIT 1
`define CTRL_DIV_LSB 2
`define CTRL_RESET 4'h0
`define ST_BUSY_BIT 0
`define ST_MODE_LSB 1
`define ST_EMPTY_BIT 3
`define ST_FULL_BIT 4
`define ST_OVERRUN_BIT 5
`define RESULT_WIDTH 16

`endif

//--- adc_seq_pkg.sv
// types shared by the conversion sequencer modules
package adc_seq_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_FAST, MODE_LOW_POWER} conv_mode_type;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_CONVERT, SEQ_DRAIN, SEQ_SYNC_LEAD, SEQ_SCLK_HIGH, SEQ_SCLK_LOW,
    SEQ_SYNC_TAIL, SEQ_BUSY_TAIL
  } seq_state_type;
endpackage

//--- result_fifo.sv
// synchronous result FIFO with valid/ready on both sides
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] level_reg;
  logic do_push;
  logic do_pop;

  // handshake terms; full really stalls the writer
  assign full = (level_reg == (AW+1)'(DEPTH));
  assign empty = (level_reg == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign do_push = in_valid && !full;
  assign do_pop = out_ready && !empty;
  assign out_data = mem[rd_ptr_reg];

  // storage is written without reset, only pointers need a defined state
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      level_reg <= level_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // result_fifo

//--- result_shifter.sv
// msb-first result shift register with a chained serial input
module result_shifter #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic shift,
  input wire logic chain_in,
  output logic bit_out,
  output logic [$clog2(WIDTH+1)-1:0] bits_left
);
  logic [WIDTH-1:0] shift_reg;
  logic [$clog2(WIDTH+1)-1:0] left_reg;

  // load wins over shift; chained bits follow the word for daisy chains
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
      left_reg <= '0;
    end else if (load) begin
      shift_reg <= load_data;
      left_reg <= ($clog2(WIDTH+1))'(WIDTH);
    end else if (shift) begin
      shift_reg <= {shift_reg[WIDTH-2:0], chain_in};
      if (left_reg != '0) begin
        left_reg <= left_reg - 1'b1;
      end
    end
  end

  assign bit_out = shift_reg[WIDTH-1];
  assign bits_left = left_reg;
endmodule // result_shifter

//--- adc_seq_asserts.sv
// port-level timing checks of the conversion sequencer
`include "adc_seq_map.svh"
module adc_seq_asserts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic convert_start_n,
  input wire logic fast_sel,
  input wire logic low_power_sel,
  input wire logic cs_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic busy,
  input wire logic [15:0] par_data,
  input wire logic serial_data_oe,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic sclk_out,
  input wire logic sclk_oe
);
  // ----------------------------------------------------------------
  // per-divider windows in cycles and master busy ceilings in ns
  // ----------------------------------------------------------------
  localparam int PER_LO [4] = '{4, 7, 13, 25};
  localparam int PER_HI [4] = '{5, 8, 17, 35};
  localparam int TAIL [4] = '{1, 8, 18, 38};
  localparam int MASTER_NS [4] = '{1500, 2000, 3000, 5250};
  logic [3:0] ctrl_reg;
  logic [15:0] bcnt_reg, pcnt_reg, fcnt_reg;
  logic sclk_d_reg, seen_reg;
  int add_ns, busy_lim;
  default clocking dclk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // pins are held per conversion, so live pins stand for the latched mode
  assign add_ns = (fast_sel && !low_power_sel) ? 0 : (low_power_sel && !fast_sel) ? 500 : 250;
  assign busy_lim = (((ctrl_reg[1:0] == 2'b11) ? MASTER_NS[ctrl_reg[3:2]] : 750) + add_ns) / 8;
  // shadow of the port setting, busy length and cycles since bit-clock edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET;
      bcnt_reg <= 16'h0000;
      pcnt_reg <= 16'h0000;
      fcnt_reg <= 16'h0000;
      sclk_d_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `OFS_CTRL) ctrl_reg <= reg_wdata[3:0];
      bcnt_reg <= busy ? bcnt_reg + 16'h0001 : 16'h0000;
      pcnt_reg <= (sclk_out && !sclk_d_reg) ? 16'h0001 : pcnt_reg + 16'h0001;
      fcnt_reg <= (!sclk_out && sclk_d_reg) ? 16'h0001 : fcnt_reg + 16'h0001;
      sclk_d_reg <= sclk_out;
      seen_reg <= sync_out && (seen_reg || sclk_out);
    end
  end
  chk_busy_rise: assert property ($fell(convert_start_n) && !busy |-> ##[1:3] busy)
    else $error("busy late after start");
  chk_busy_max: assert property (busy |-> bcnt_reg < busy_lim)
    else $error("busy too long");
  chk_data_lead: assert property ($fell(busy) && !ctrl_reg[0] |->
    $stable(par_data) && par_data == $past(par_data, 2))
    else $error("data not settled before busy fell");
  chk_oe_release: assert property (cs_n |=> !sync_oe && !sclk_oe && !serial_data_oe)
    else $error("serial outputs not released");
  chk_lead_short: assert property ($rose(sync_out) && ctrl_reg[3:2] == 2'b00 |-> !sclk_out)
    else $error("bit clock with frame sync");
  chk_lead_long: assert property ($rose(sync_out) && ctrl_reg[3:2] != 2'b00 |-> !sclk_out [*3])
    else $error("bit clock too soon");
  chk_sclk_period: assert property ($rose(sclk_out) && seen_reg |->
    pcnt_reg >= PER_LO[ctrl_reg[3:2]] && pcnt_reg <= PER_HI[ctrl_reg[3:2]])
    else $error("bit clock period out of range");
  chk_sync_tail: assert property ($fell(sync_out) |-> fcnt_reg >= TAIL[ctrl_reg[3:2]])
    else $error("frame sync tail short");
  chk_busy_drop: assert property ($fell(sync_out) |-> busy [*2] ##[1:3] !busy)
    else $error("busy not dropped after frame");
endmodule // adc_seq_asserts

bind adc_seq_core adc_seq_asserts chk (.ref_clk, .rst_n, .convert_start_n, .fast_sel,
  .low_power_sel, .cs_n, .reg_addr, .reg_wdata, .reg_wr, .busy, .par_data,
  .serial_data_oe, .sync_out, .sync_oe, .sclk_out, .sclk_oe);

//--- host_serial_rx.sv
// host receiver model capturing the master serial result stream
module host_serial_rx (
  input wire logic ref_clk,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic sclk_out,
  input wire logic serial_data_out,
  output logic [15:0] word,
  output int nbits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_d, sync_d;
  // capture one cycle after the rising bit clock; the data change on the edge that raises it
  always @(posedge ref_clk) begin
    sclk_d <= sclk_out;
    sync_d <= sync_out;
    if (sync_out && !sync_d) nbits <= 0;
    else if (sync_oe && sync_out && sclk_out && !sclk_d) begin
      word <= {word[14:0], serial_data_out};
      nbits <= nbits + 1;
    end
  end
endmodule // host_serial_rx

//--- tb.sv
// self-checking bench of the conversion sequencer with a serial host model
`include "adc_seq_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, convert_start_n = 1'b1, fast_sel = 1'b0;
  logic low_power_sel = 1'b0, cs_n = 1'b1, rd_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] sample_code = 16'h0000, par_data, rx_word, e;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic busy, core_power_up, par_data_oe, serial_data_out, serial_data_oe;
  logic sync_out, sync_oe, sclk_out, sclk_oe;
  logic [15:0] exp_q [$];
  int rx_bits, md, seed, num_errors = 0, compares = 0, conv_count = 0;

  adc_seq_core dut (.ref_clk, .rst_n, .convert_start_n, .fast_sel, .low_power_sel,
    .sample_code, .cs_n, .rd_n, .ext_sclk(1'b0), .serial_data_in(1'b0), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .busy, .core_power_up, .par_data, .par_data_oe,
    .serial_data_out, .serial_data_oe, .sync_out, .sync_oe, .sclk_out, .sclk_oe);
  host_serial_rx host (.ref_clk, .sync_out, .sync_oe, .sclk_out, .serial_data_out,
    .word(rx_word), .nbits(rx_bits));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    num_errors++;
    results();
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  // start one conversion; a retrigger strobe lands while busy and must be ignored
  task automatic convert(input logic [15:0] code, input logic retrig);
    int n;
    repeat (200) @(posedge ref_clk);
    sample_code <= code;
    exp_q.push_back(code);
    convert_start_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    convert_start_n <= 1'b1;
    #1 check("busy rise", {31'h0, busy}, 32'h1);
    n = 0;
    while (busy === 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      convert_start_n <= !(retrig && n == 10);
      #1 n++;
    end
    check("busy fall", {31'h0, busy}, 32'h0);
    conv_count++;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 29217;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reg_write(8'h10, 32'hFFFF_FFFF);
    reg_read(`OFS_CTRL, d);
    check("ctrl reset", d, 32'h0);
    reg_read(`OFS_STATUS, d);
    check("status reset", d, 32'h1 << `ST_EMPTY_BIT);
    reg_read(8'h10, d);
    check("unmapped", d, 32'h0);
    $display("test registers done");
    // parallel port through all four select combinations
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      {fast_sel, low_power_sel} <= m[1:0];
      md = (m == 1) ? 2 : (m == 2) ? 1 : 0;
      convert($random(seed), m == 3);
      e = exp_q.pop_front();
      check("par data", {15'h0, par_data_oe, par_data}, {16'h1, e});
      check("power", {31'h0, core_power_up}, {31'h0, m != 1});
      @(posedge ref_clk);
      reg_read(`OFS_STATUS, d);
      check("status mode", d, 32'(md * 2 + 8));
      reg_read(`OFS_RESULT, d);
      check("result", d, {16'h0, e});
    end
    $display("test parallel done");
    rd_n <= 1'b1;
    for (int dv = 0; dv < 4; dv++) begin
      reg_write(`OFS_CTRL, 32'(dv * 4 + 3));
      convert($random(seed), 1'b0);
      e = exp_q.pop_front();
      check("serial word", {16'h0, rx_word}, {16'h0, e});
      check("serial bits", 32'(rx_bits), 32'd16);
      @(posedge ref_clk);
    end
    $display("test master serial done");
    cs_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check("release", {29'h0, sync_oe, sclk_oe, serial_data_oe}, 32'h0);
    @(posedge ref_clk);
    reg_read(`OFS_COUNT, d);
    check("count", d, 32'(conv_count));
    $display("test release done");
    results();
  end
endmodule // tb
